/* File: bus_host_model.sv */
// Two-wire bus host model: drives the clock level directly and pulls data low as an open-drain line
`timescale 1ns/100ps
module bus_host_model (
   input  wire logic i_clk_sys,   // System clock
   input  wire logic i_sda_line,  // Resolved data line
   output logic      o_scl,       // Bus clock level
   output logic      o_sda_low    // High pulls data low
);
   initial begin
      o_scl     = 1'b1;
      o_sda_low = 1'b0;
   end
   ////////////////////////////////////////////////////////////////////////////
   // Four clocks a phase keeps every bus edge well apart
   task automatic phase();
      repeat (4) @(negedge i_clk_sys);
   endtask : phase
   // Also serves as repeated start
   task automatic start();
      o_sda_low = 1'b0;
      phase();
      o_scl = 1'b1;
      phase();
      o_sda_low = 1'b1;
      phase();
      o_scl = 1'b0;
   endtask : start
   task automatic stop();
      o_sda_low = 1'b1;
      phase();
      o_scl = 1'b1;
      phase();
      o_sda_low = 1'b0;
      phase();
   endtask : stop
   // Data changes only while clock is low
   task automatic bit_xfer(input logic b, output logic r);
      phase();
      o_sda_low = ~b;
      phase();
      o_scl = 1'b1;
      phase();
      r = i_sda_line;
      phase();
      o_scl = 1'b0;
   endtask : bit_xfer
   ////////////////////////////////////////////////////////////////////////////
   // direction bit travels as bit eight
   task automatic write_byte(input logic [7:0] d, output logic ack);
      logic r;
      for (int i = 7; i >= 0; i--) bit_xfer(d[i], r);
      bit_xfer(1'b1, r);
      ack = ~r;
   endtask : write_byte
   // Low on ninth bit asks for more, high ends the read
   task automatic read_byte(input logic give_ack, output logic [7:0] d);
      logic r;
      for (int i = 7; i >= 0; i--) bit_xfer(1'b1, d[i]);
      bit_xfer(~give_ack, r);
   endtask : read_byte
endmodule : bus_host_model

/* File: tb_top.sv */
// Self-checking testbench for the thermal alarm and bus address block
`timescale 1ns/100ps
module tb_top
   import thermal_alarm_pkg::*;
;
   logic              clk, rst_n, scl, host_low, sda_line, sda_o, sda_oe;
   logic [2:0]        strap;
   logic [BYTE_W-1:0] rd_data, wr_data, wr_seen, d, n_wr, n_rd;
   logic              rd_req, wr_valid, temp_valid, int_mode, pol, shutdown, al_o, al_oe, ack;
   logic [TEMP_W-1:0] temp, upper, lower;
   int                n_mismatch, checks;

   // Pull-up on data unless someone pulls low
   assign sda_line = ~host_low & (sda_oe ? sda_o : 1'b1);
   initial clk = 1'b0;
   always #2.5 clk = ~clk;

   bus_host_model host_u (.i_clk_sys(clk), .i_sda_line(sda_line), .o_scl(scl), .o_sda_low(host_low));
   thermal_alarm_and_bus_address dut_u (
      .i_clk_sys(clk), .i_rst_n(rst_n), .i_scl(scl), .i_sda(sda_line), .o_sda_o(sda_o), .o_sda_oe(sda_oe),
      .i_addr_select_hi(strap[2]), .i_addr_select_mid(strap[1]), .i_addr_select_lo(strap[0]),
      .i_rd_data(rd_data), .o_rd_req(rd_req), .o_wr_data(wr_data), .o_wr_valid(wr_valid),
      .i_temp(temp), .i_temp_valid(temp_valid), .i_upper_trip(upper), .i_lower_release_point(lower),
      .i_int_mode(int_mode), .i_alarm_polarity_bit(pol), .i_shutdown(shutdown),
      .o_thermal_alarm_out_o(al_o), .o_thermal_alarm_out_oe(al_oe));

   // Counting pulses lets one check catch doubled or missing strobes
   always @(negedge clk) begin
      if (wr_valid === 1'b1) begin
         wr_seen <= wr_data;
         n_wr    <= n_wr + 8'h01;
      end
      if (rd_req === 1'b1) n_rd <= n_rd + 8'h01;
   end
   ////////////////////////////////////////////////////////////////////////////
   task automatic chk_bit(input logic got, input logic exp);
      checks++;
      if (got !== exp) begin
         n_mismatch++;
         $display("[FAIL] t=%0t got=%0h exp=%0h", $time, got, exp);
      end
   endtask : chk_bit
   task automatic chk_byte(input logic [7:0] got, input logic [7:0] exp);
      checks++;
      if (got !== exp) begin
         n_mismatch++;
         $display("[FAIL] t=%0t got=%0h exp=%0h", $time, got, exp);
      end
   endtask : chk_byte
   task automatic results();
      $display("Checks %0d mismatches %0d", checks, n_mismatch);
      if (n_mismatch == 0 && checks > 0)
         $display("Testbench passed");
      else
         $display("Testbench failed");
      $finish;
   endtask : results
   ////////////////////////////////////////////////////////////////////////////
   task automatic do_reset();
      rst_n = 1'b0;
      repeat (2) @(negedge clk);
      rst_n = 1'b1;
      repeat (2) @(negedge clk);
   endtask : do_reset
   task automatic conv(input logic [TEMP_W-1:0] t);
      @(negedge clk);
      temp       = t;
      temp_valid = 1'b1;
      @(negedge clk);
      temp_valid = 1'b0;
      @(negedge clk);
   endtask : conv
   // Pin level from pull-up; drive value must never be high
   task automatic chk_alarm(input logic act);
      chk_bit(al_oe ? al_o : 1'b1, act ? pol : ~pol);
      chk_bit(al_o, 1'b0);
   endtask : chk_alarm
   task automatic addr_try(input logic [7:0] a, input logic exp);
      host_u.start();
      host_u.write_byte(a, ack);
      chk_bit(ack, exp);
      host_u.stop();
   endtask : addr_try
   task automatic reg_read(output logic [7:0] v);
      host_u.start();
      host_u.write_byte({ADDR_PREFIX, strap, READ_BIT}, ack);
      chk_bit(ack, 1'b1);
      host_u.read_byte(1'b0, v);
      host_u.stop();
   endtask : reg_read
   ////////////////////////////////////////////////////////////////////////////
   // Full run needs about 6000 clocks; this allows more than three times that
   initial begin
      #100000;
      n_mismatch++;
      results();
   end
   initial begin
      {rst_n, strap, rd_data, temp, temp_valid, int_mode, pol, shutdown} = '0;
      {n_wr, n_rd, wr_seen, n_mismatch, checks} = '0;
      upper = 9'h050;
      lower = 9'h04B;
      do_reset();
      chk_alarm(1'b0);
      chk_byte(wr_data, BYTE_RST);
      for (int s = 0; s < 8; s++) begin
         strap = s[2:0];
         addr_try({ADDR_PREFIX, strap, 1'b0}, 1'b1);
         addr_try({ADDR_PREFIX, strap ^ (3'h1 << (s % 3)), 1'b0}, 1'b0);
         addr_try({4'h1, strap, 1'b0}, 1'b0);
      end
      strap = 3'h5;
      host_u.start();
      host_u.write_byte({ADDR_PREFIX, strap, 1'b0}, ack);
      chk_bit(ack, 1'b1);
      host_u.write_byte(8'hA5, ack);
      chk_bit(ack, 1'b1);
      chk_byte(wr_seen, 8'hA5);
      host_u.write_byte(8'h3C, ack);
      chk_bit(ack, 1'b1);
      host_u.stop();
      chk_byte(wr_seen, 8'h3C);
      chk_byte(n_wr, 8'h02);
      rd_data = 8'hC3;
      reg_read(d);
      chk_byte(d, 8'hC3);
      chk_byte(n_rd, 8'h01);
      // Repeated start into a two-byte read: host ack fetches a second byte
      rd_data = 8'h96;
      host_u.start();
      host_u.write_byte({ADDR_PREFIX, strap, 1'b0}, ack);
      chk_bit(ack, 1'b1);
      host_u.start();
      host_u.write_byte({ADDR_PREFIX, strap, READ_BIT}, ack);
      chk_bit(ack, 1'b1);
      host_u.read_byte(1'b1, d);
      chk_byte(d, 8'h96);
      host_u.read_byte(1'b0, d);
      chk_byte(d, 8'h96);
      host_u.stop();
      chk_byte(n_rd, 8'h03);
      chk_byte(n_wr, 8'h02);
      // Comparator mode
      @(negedge clk);
      temp = 9'h0FF;
      repeat (4) @(negedge clk);
      chk_alarm(1'b0);
      conv(9'h051);
      chk_alarm(1'b1);
      conv(9'h04C);
      chk_alarm(1'b1);
      conv(9'h04B);
      chk_alarm(1'b1);
      conv(9'h04A);
      chk_alarm(1'b0);
      conv(9'h051);
      shutdown = 1'b1;
      conv(9'h040);
      chk_alarm(1'b1);
      shutdown = 1'b0;
      conv(9'h040);
      chk_alarm(1'b0);
      // Interrupt mode from a clean state
      int_mode = 1'b1;
      do_reset();
      conv(9'h051);
      chk_alarm(1'b1);
      conv(9'h04C);
      chk_alarm(1'b1);
      reg_read(d);
      chk_alarm(1'b0);
      conv(9'h04C);
      chk_alarm(1'b0);
      conv(9'h040);
      chk_alarm(1'b1);
      reg_read(d);
      chk_alarm(1'b0);
      conv(9'h051);
      chk_alarm(1'b1);
      shutdown = 1'b1;
      repeat (2) @(negedge clk);
      chk_alarm(1'b0);
      shutdown = 1'b0;
      // Active-high polarity
      int_mode = 1'b0;
      pol      = 1'b1;
      do_reset();
      chk_alarm(1'b0);
      conv(9'h051);
      chk_alarm(1'b1);
      conv(9'h040);
      chk_alarm(1'b0);
      results();
   end
endmodule : tb_top

/* File: thermal_alarm_and_bus_address.sv */
// Top: two-wire slave address match and byte ack, plus thermal alarm pin
`timescale 1ns/100ps
module thermal_alarm_and_bus_address
   import thermal_alarm_pkg::*;
(
   input  wire logic              i_clk_sys,              // System clock, 200 MHz
   input  wire logic              i_rst_n,                // Sync reset, active low
   input  wire logic              i_scl,                  // Bus clock level
   input  wire logic              i_sda,                  // Bus data level
   output logic                   o_sda_o,                // Data drive value
   output logic                   o_sda_oe,               // Data pull-low enable
   input  wire logic              i_addr_select_hi,       // Strap, top address bit
   input  wire logic              i_addr_select_mid,      // Strap, middle address bit
   input  wire logic              i_addr_select_lo,       // Strap, bottom address bit
   input  wire logic [BYTE_W-1:0] i_rd_data,              // Byte to send on read
   output logic                   o_rd_req,               // Read byte taken pulse
   output logic [BYTE_W-1:0]      o_wr_data,              // Byte written by host
   output logic                   o_wr_valid,             // Written byte pulse
   input  wire logic [TEMP_W-1:0] i_temp,                 // Conversion result
   input  wire logic              i_temp_valid,           // Conversion done pulse
   input  wire logic [TEMP_W-1:0] i_upper_trip,           // Upper trip point
   input  wire logic [TEMP_W-1:0] i_lower_release_point,  // Lower release point
   input  wire logic              i_int_mode,             // 1 interrupt, 0 comparator
   input  wire logic              i_alarm_polarity_bit,   // 1 active high, 0 active low
   input  wire logic              i_shutdown,             // Shutdown level
   output logic                   o_thermal_alarm_out_o,  // Alarm drive value
   output logic                   o_thermal_alarm_out_oe  // Alarm pull-low enable
);

   typedef struct packed {
      bus_state_e        st;
      logic              scl_q;
      logic              sda_q;
      logic [3:0]        cnt;
      logic [BYTE_W-1:0] sh;
      logic              rw;
      logic              more;
      logic              sda_oe;
      logic [BYTE_W-1:0] wr_data;
      logic              wr_valid;
      logic              rd_req;
      logic              reg_read;
   } bus_s;

   bus_s              bus_r;
   bus_s              bus_nxt;
   logic              scl_rise;
   logic              scl_fall;
   logic              start_det;
   logic              stop_det;
   logic              addr_hit;
   logic [ADDR_W-1:0] own_addr;

   ////////////////////////////////////////////////////////////////////////////
   // Line events; pins are already synchronous to the system clock
   always_comb begin
      scl_rise  = i_scl && !bus_r.scl_q;
      scl_fall  = !i_scl && bus_r.scl_q;
      start_det = i_scl && bus_r.scl_q && bus_r.sda_q && !i_sda;
      stop_det  = i_scl && bus_r.scl_q && !bus_r.sda_q && i_sda;
   end

   assign own_addr = {ADDR_PREFIX, i_addr_select_hi, i_addr_select_mid, i_addr_select_lo};
   assign addr_hit = (bus_r.sh[BYTE_W-1:1] == own_addr);

   ////////////////////////////////////////////////////////////////////////////
   always_comb begin
      bus_nxt          = bus_r;
      bus_nxt.scl_q    = i_scl;
      bus_nxt.sda_q    = i_sda;
      bus_nxt.wr_valid = 1'b0;
      bus_nxt.rd_req   = 1'b0;
      bus_nxt.reg_read = 1'b0;
      // Start and stop win over any byte in progress, also repeated start
      if (start_det) begin
         bus_nxt.st     = S_ADDR;
         bus_nxt.cnt    = BIT_CNT_RST;
         bus_nxt.sda_oe = 1'b0;
      end else if (stop_det) begin
         bus_nxt.st     = S_IDLE;
         bus_nxt.sda_oe = 1'b0;
      end else begin
         case (bus_r.st)
            S_IDLE: begin
               bus_nxt.sda_oe = 1'b0;
            end
            S_ADDR: begin
               if (scl_rise) begin
                  bus_nxt.sh  = {bus_r.sh[BYTE_W-2:0], i_sda};
                  bus_nxt.cnt = bus_r.cnt + BIT_CNT_ONE;
               end else if (scl_fall && bus_r.cnt == BIT_CNT_BYTE) begin
                  // silent on mismatch, bus left to others
                  if (addr_hit) begin
                     bus_nxt.st     = S_ADDR_AK;
                     bus_nxt.sda_oe = 1'b1;
                     bus_nxt.rw     = (bus_r.sh[0] == READ_BIT);
                  end else begin
                     bus_nxt.st = S_IDLE;
                  end
               end
            end
            S_ADDR_AK: begin
               if (scl_fall) begin
                  bus_nxt.cnt = BIT_CNT_RST;
                  if (bus_r.rw) begin
                     // First read byte goes out at once; alarm sees a register read
                     bus_nxt.st       = S_RD_DATA;
                     bus_nxt.sh       = i_rd_data;
                     bus_nxt.sda_oe   = ~i_rd_data[BYTE_W-1];
                     bus_nxt.rd_req   = 1'b1;
                     bus_nxt.reg_read = 1'b1;
                  end else begin
                     bus_nxt.st     = S_WR_DATA;
                     bus_nxt.sda_oe = 1'b0;
                  end
               end
            end
            S_WR_DATA: begin
               if (scl_rise) begin
                  bus_nxt.sh  = {bus_r.sh[BYTE_W-2:0], i_sda};
                  bus_nxt.cnt = bus_r.cnt + BIT_CNT_ONE;
               end else if (scl_fall && bus_r.cnt == BIT_CNT_BYTE) begin
                  bus_nxt.st       = S_WR_AK;
                  bus_nxt.sda_oe   = 1'b1;
                  bus_nxt.wr_data  = bus_r.sh;
                  bus_nxt.wr_valid = 1'b1;
               end
            end
            S_WR_AK: begin
               if (scl_fall) begin
                  bus_nxt.st     = S_WR_DATA;
                  bus_nxt.cnt    = BIT_CNT_RST;
                  bus_nxt.sda_oe = 1'b0;
               end
            end
            S_RD_DATA: begin
               if (scl_rise) begin
                  bus_nxt.cnt = bus_r.cnt + BIT_CNT_ONE;
               end else if (scl_fall) begin
                  if (bus_r.cnt == BIT_CNT_BYTE) begin
                     // Release for the host's acknowledge
                     bus_nxt.st     = S_RD_AK;
                     bus_nxt.sda_oe = 1'b0;
                  end else begin
                     bus_nxt.sh     = {bus_r.sh[BYTE_W-2:0], 1'b0};
                     bus_nxt.sda_oe = ~bus_r.sh[BYTE_W-2];
                  end
               end
            end
            S_RD_AK: begin
               if (scl_rise) begin
                  bus_nxt.more = !i_sda;
               end else if (scl_fall) begin
                  // A host NACK ends the read; we wait for stop idle
                  if (bus_r.more) begin
                     bus_nxt.st     = S_RD_DATA;
                     bus_nxt.cnt    = BIT_CNT_RST;
                     bus_nxt.sh     = i_rd_data;
                     bus_nxt.sda_oe = ~i_rd_data[BYTE_W-1];
                     bus_nxt.rd_req = 1'b1;
                  end else begin
                     bus_nxt.st = S_IDLE;
                  end
               end
            end
            default: begin
               bus_nxt.st     = S_IDLE;
               bus_nxt.sda_oe = 1'b0;
            end
         endcase
      end
   end

   always_ff @(posedge i_clk_sys) begin
      if (!i_rst_n) begin
         bus_r         <= '0;
         bus_r.st      <= S_IDLE;
         bus_r.scl_q   <= 1'b1;
         bus_r.sda_q   <= 1'b1;
         bus_r.cnt     <= BIT_CNT_RST;
         bus_r.sh      <= BYTE_RST;
         bus_r.wr_data <= BYTE_RST;
      end else begin
         bus_r <= bus_nxt;
      end
   end

   // Data line only ever pulled low, never driven high
   assign o_sda_o    = 1'b0;
   assign o_sda_oe   = bus_r.sda_oe;
   assign o_wr_data  = bus_r.wr_data;
   assign o_wr_valid = bus_r.wr_valid;
   assign o_rd_req   = bus_r.rd_req;

   ////////////////////////////////////////////////////////////////////////////
   // Alarm pin; the register read pulse comes from the bus engine above
   thermal_alarm_logic u_alarm (
      .i_clk_sys    (i_clk_sys),
      .i_rst_n      (i_rst_n),
      .i_temp       (i_temp),
      .i_temp_valid (i_temp_valid),
      .i_upper_trip (i_upper_trip),
      .i_lower_rel  (i_lower_release_point),
      .i_int_mode   (i_int_mode),
      .i_pol        (i_alarm_polarity_bit),
      .i_shutdown   (i_shutdown),
      .i_reg_read   (bus_r.reg_read),
      .o_alarm_o    (o_thermal_alarm_out_o),
      .o_alarm_oe   (o_thermal_alarm_out_oe)
   );

   ////////////////////////////////////////////////////////////////////////////
   default clocking cb @(posedge i_clk_sys); endclocking
   default disable iff (!i_rst_n);

   a_addr_prefix: assert property (own_addr[ADDR_W-1:ADDR_W-4] == 4'h9)
      else $error("address prefix is not 1001");
   a_addr_nack: assert property ((bus_r.st == S_ADDR && scl_fall && bus_r.cnt == BIT_CNT_BYTE
                                  && !start_det && !stop_det && !addr_hit) |=> !o_sda_oe && bus_r.st == S_IDLE)
      else $error("acked a foreign address");
   a_addr_ack: assert property ((bus_r.st == S_ADDR && scl_fall && bus_r.cnt == BIT_CNT_BYTE
                                 && !start_det && !stop_det && addr_hit) |=> o_sda_oe)
      else $error("own address not acked");
   a_strap_order: assert property (own_addr[2:0] == {i_addr_select_hi, i_addr_select_mid, i_addr_select_lo})
      else $error("strap bits out of order");
   a_read_dir: assert property ((bus_r.st == S_ADDR_AK && scl_fall && !start_det && !stop_det && bus_r.rw)
                                |=> bus_r.st == S_RD_DATA && $past(bus_nxt.reg_read))
      else $error("read direction not followed");
   a_write_ack: assert property ((bus_r.st == S_WR_DATA && scl_fall && bus_r.cnt == BIT_CNT_BYTE
                                  && !start_det && !stop_det) |=> o_sda_oe && o_wr_valid ##1 !o_wr_valid)
      else $error("written byte not acked");

   c_addr_ack: cover property (bus_r.st == S_ADDR_AK && o_sda_oe);
   c_write_ack: cover property (o_wr_valid);

endmodule : thermal_alarm_and_bus_address

/* File: thermal_alarm_logic.sv */
// Alarm pin logic: comparator and interrupt modes, polarity, shutdown
`timescale 1ns/100ps
module thermal_alarm_logic
   import thermal_alarm_pkg::*;
(
   input  wire logic              i_clk_sys,    // System clock
   input  wire logic              i_rst_n,      // Sync reset, active low
   input  wire logic [TEMP_W-1:0] i_temp,       // Latest conversion result
   input  wire logic              i_temp_valid, // Conversion done pulse
   input  wire logic [TEMP_W-1:0] i_upper_trip, // Upper trip point
   input  wire logic [TEMP_W-1:0] i_lower_rel,  // Lower release point
   input  wire logic              i_int_mode,   // 1 interrupt, 0 comparator
   input  wire logic              i_pol,        // 1 active high, 0 active low
   input  wire logic              i_shutdown,   // Shutdown level
   input  wire logic              i_reg_read,   // Register read pulse
   output logic                   o_alarm_o,    // Alarm pin drive value
   output logic                   o_alarm_oe    // Alarm pin pull-low enable
);

   typedef struct packed {
      logic cmp_on;
      logic pend;
      logic phase_lo;
      logic sd_q;
      logic act;
      logic pol;
      logic pin_oe;
      logic pin_o;
   } alarm_s;

   alarm_s st_r;
   alarm_s st_nxt;
   logic   conv;
   logic   hi;
   logic   lo;
   logic   ev;
   logic   sd_enter;

   ////////////////////////////////////////////////////////////////////////////
   always_comb begin
      st_nxt    = st_r;
      sd_enter  = i_shutdown && !st_r.sd_q;
      conv      = i_temp_valid && !i_shutdown;
      hi        = conv && temp_above(i_temp, i_upper_trip);
      lo        = conv && temp_below(i_temp, i_lower_rel);
      st_nxt.sd_q = i_shutdown;
      if (hi) begin
         st_nxt.cmp_on = 1'b1;
      end else if (lo) begin
         st_nxt.cmp_on = 1'b0;
      end
      ev = i_int_mode && ((!st_r.phase_lo && hi) || (st_r.phase_lo && lo));
      if (ev) begin
         st_nxt.phase_lo = ~st_r.phase_lo;
      end
      if (i_int_mode && sd_enter) begin
         st_nxt.pend = 1'b0;
      // latch event; set beats read clear
      end else if (ev) begin
         st_nxt.pend = 1'b1;
      end else if (i_reg_read) begin
         st_nxt.pend = 1'b0;
      end
      st_nxt.act    = i_int_mode ? st_nxt.pend : st_nxt.cmp_on;
      st_nxt.pol    = i_pol;
      // open drain, only ever pulls low
      st_nxt.pin_oe = st_nxt.act ? ~i_pol : i_pol;
      st_nxt.pin_o  = 1'b0;
   end

   always_ff @(posedge i_clk_sys) begin
      if (!i_rst_n) begin
         st_r     <= '0;
         st_r.pol <= ALARM_POL_RST;
      end else begin
         st_r <= st_nxt;
      end
   end

   assign o_alarm_o  = st_r.pin_o;
   assign o_alarm_oe = st_r.pin_oe;

   ////////////////////////////////////////////////////////////////////////////
   default clocking cb @(posedge i_clk_sys); endclocking
   default disable iff (!i_rst_n);

   a_cmp_trip_on: assert property (hi |=> st_r.cmp_on)
      else $error("comparator did not trip above upper point");
   a_cmp_hold_band: assert property ((st_r.cmp_on && !lo) |=> st_r.cmp_on ##0 !$fell(st_r.cmp_on))
      else $error("comparator released without a low reading");
   a_cmp_sd_hold: assert property (i_shutdown |=> $stable(st_r.cmp_on))
      else $error("comparator state moved in shutdown");
   a_int_latch: assert property ((st_r.pend && !i_reg_read && !sd_enter) |=> st_r.pend)
      else $error("interrupt latch dropped without clear");
   a_int_rd_clear: assert property ((i_reg_read && !ev) |=> !st_r.pend)
      else $error("register read did not clear interrupt");
   a_int_low_event: assert property ((i_int_mode && st_r.phase_lo && lo && !sd_enter) |=> st_r.pend)
      else $error("release event did not raise interrupt");
   a_int_sd_clear: assert property ((i_int_mode && sd_enter) |=> !st_r.pend ##1 (st_r.pend == $past(ev)))
      else $error("shutdown entry did not clear interrupt");
   a_pol_pin_map: assert property (##1 o_alarm_oe == (st_r.act ? !st_r.pol : st_r.pol))
      else $error("alarm pin level does not follow polarity");
   a_open_drain: assert property (o_alarm_o == 1'b0)
      else $error("alarm pin driven high");
   a_eval_per_conv: assert property (!i_temp_valid |=> $stable(st_r.cmp_on))
      else $error("comparison changed between conversions");

   c_cmp_trip: cover property (!i_int_mode ##0 hi ##1 st_r.act);
   c_int_read: cover property (st_r.pend ##1 i_reg_read ##1 !st_r.pend);
   c_int_release: cover property (st_r.phase_lo && lo && i_int_mode);

endmodule : thermal_alarm_logic

/* File: thermal_alarm_pkg.sv */
// Shared constants, types and helpers for the thermal alarm and bus address block
package thermal_alarm_pkg;

   // Temperature word: two's complement, as delivered by the converter
   localparam int           TEMP_W         = 9;
   localparam int           BYTE_W         = 8;
   localparam int           ADDR_W         = 7;

   // Fixed upper part of the seven-bit slave address
   localparam logic [3:0]   ADDR_PREFIX    = 4'h9;

   // Bit counter values
   localparam logic [3:0]   BIT_CNT_RST    = 4'h0;
   localparam logic [3:0]   BIT_CNT_BYTE   = 4'h8;
   localparam logic [3:0]   BIT_CNT_ONE    = 4'h1;

   // Reset values, and the read direction bit value
   localparam logic [7:0]   BYTE_RST       = 8'h00;
   localparam logic         ALARM_POL_RST  = 1'b0;
   localparam logic         READ_BIT       = 1'b1;

   typedef enum logic [6:0] {
      S_IDLE    = 7'h01,
      S_ADDR    = 7'h02,
      S_ADDR_AK = 7'h04,
      S_WR_DATA = 7'h08,
      S_WR_AK   = 7'h10,
      S_RD_DATA = 7'h20,
      S_RD_AK   = 7'h40
   } bus_state_e;

   function automatic logic temp_above(input logic [TEMP_W-1:0] t, input logic [TEMP_W-1:0] lim);
      temp_above = $signed(t) > $signed(lim);
   endfunction : temp_above

   function automatic logic temp_below(input logic [TEMP_W-1:0] t, input logic [TEMP_W-1:0] lim);
      temp_below = $signed(t) < $signed(lim);
   endfunction : temp_below

endpackage : thermal_alarm_pkg
